// file: src/ascii_digit_selection_decoder.sv
`default_nettype none

// Operation
// - a falling line edge fires an 11 ms start-detect pulse unless one is already running
// - start pulse end opens a 70 ms data window over bits 1 to 8
// - start pulses during an open window launch nothing new
// - open window runs the bit clock and gates data into the register
// - registers and decoders see only the eight data bits
// - ten-bit register of two five-bit sections, one clear to zero
// - each of the first eight bit clocks in a window moves every stage up, stage 1 takes the input
// - after eight shifts the first bit sits in stage 8, last in stage 1
// - only pattern 00011001 is detected and held as the entry character
// - held entry character raises the entry gate to the digit register
// - entry gate is forced off while the data window is open
// - digit register equals the control register, decodes digits 0 to 9
// - first four received bits pick at most one of ten selects
// - the six codes above nine select nothing
// - trailing bits 1101 mark a fully loaded digit
// - all selects stay inactive while a digit is shifting in
// - empty register never selects digit zero
// - digit selects are active low
// - bit clock is gated, with separately set width and rate
// - digit zero select passes only while first digit done is high
// - done freezes the digit register and enables the next stage
// - clear pulse zeroes every register but the line synchroniser and sets all selects inactive, awaiting entry
module ascii_digit_selection_decoder
	import ascii_decoder_pkg::*;
#(
	parameter int START_LEN  = START_CYCLES,
	parameter int WINDOW_LEN = WINDOW_CYCLES,
	parameter int BIT_PERIOD = BIT_PERIOD_CYCLES,
	parameter int BIT_HIGH   = BIT_HIGH_CYCLES
) (
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              rx_line,
	input  wire logic              clear_in,
	output var  logic              start_detect,
	output var  logic              data_window,
	output var  logic              bit_clock,
	output var  logic              entry_gate,
	output var  logic              first_digit_done,
	output var  logic [DIGITS-1:0] digit_select_n
);

	// terminal counts, cut to the counter width once here
	localparam logic [COUNT_W-1:0] START_LAST  = COUNT_W'(START_LEN - 1);
	localparam logic [COUNT_W-1:0] WINDOW_LAST = COUNT_W'(WINDOW_LEN - 1);
	localparam logic [COUNT_W-1:0] PERIOD_LAST = COUNT_W'(BIT_PERIOD - 1);
	localparam logic [COUNT_W-1:0] HIGH_COUNT  = COUNT_W'(BIT_HIGH);

	// turns a 4-bit code into ten active-low selects
	function automatic logic [DIGITS-1:0] select_of(
		input logic [3:0] code
	);
		logic [DIGITS-1:0] sel;
		sel = SELECT_NONE;
		if (code < 4'hA) begin
			sel[code] = 1'h0;
		end
		return sel;
	endfunction

	// line synchroniser and edge history
	logic rx_meta;
	logic rx_sync;
	logic rx_prev;
	logic rx_fall;

	// one-shot timers
	logic [COUNT_W-1:0] start_count;
	logic [COUNT_W-1:0] window_count;
	logic               start_end;
	logic               next_data_window;

	// bit clock generator
	logic [COUNT_W-1:0] bit_phase;
	logic [SHIFT_W-1:0] shift_count;
	logic               shift_tick;

	// decision state
	logic        clear_all;
	logic        entry_held;
	logic        next_entry_held;
	logic        next_done;
	logic        entry_match;
	logic        suffix_match;
	logic [3:0]  digit_code;
	logic [DIGITS-1:0] next_select_n;

	// two character registers
	shift_port_if control_port ();
	shift_port_if digit_port ();

	// the clear input and reset both wipe the decoder state
	assign clear_all = sys_rst || clear_in;

	// two flops before anything looks at the line; idle is marking
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_meta <= RX_IDLE;
			rx_sync <= RX_IDLE;
			rx_prev <= RX_IDLE;
		end else begin
			rx_meta <= rx_line;
			rx_sync <= rx_meta;
			rx_prev <= rx_sync;
		end
	end

	// falling edge taken from the second flop and its history only
	assign rx_fall = rx_prev && !rx_sync;

	// start-detect one-shot; not retriggered while it is running,
	// so a later edge inside the pulse is simply absorbed
	always_ff @(posedge clk) begin
		if (clear_all) begin
			start_detect <= 1'h0;
			start_count  <= '0;
		end else if (!start_detect) begin
			if (rx_fall) begin
				start_detect <= 1'h1;
				start_count  <= START_LAST;
			end
		end else if (start_count == '0) begin
			start_detect <= 1'h0;
		end else begin
			start_count <= start_count - 1'h1;
		end
	end

	// last cycle of the start pulse: the trailing edge follows it
	assign start_end = start_detect && (start_count == '0);

	// window opens on the start pulse trailing edge only when idle;
	// data-bit edges fire the start one-shot again but go nowhere
	always_comb begin
		if (data_window) begin
			next_data_window = (window_count != '0);
		end else begin
			next_data_window = start_end;
		end
	end

	// window length counter
	always_ff @(posedge clk) begin
		if (clear_all) begin
			data_window  <= 1'h0;
			window_count <= '0;
		end else begin
			data_window <= next_data_window;
			if (!data_window && start_end) begin
				window_count <= WINDOW_LAST;
			end else if (window_count != '0) begin
				window_count <= window_count - 1'h1;
			end
		end
	end

	// gated oscillator: phase runs only inside the window and restarts
	// at zero each time, so the first shift lands as the window opens
	always_ff @(posedge clk) begin
		if (clear_all || !data_window) begin
			bit_phase <= '0;
		end else if (bit_phase == PERIOD_LAST) begin
			bit_phase <= '0;
		end else begin
			bit_phase <= bit_phase + 1'h1;
		end
	end

	// visible bit clock: high part of each period, width set apart
	always_ff @(posedge clk) begin
		if (clear_all) begin
			bit_clock <= 1'h0;
		end else begin
			bit_clock <= data_window && (bit_phase < HIGH_COUNT);
		end
	end

	// a shift happens at the start of each period, eight at the most,
	// so stray periods near the window end never reach the register
	assign shift_tick = data_window && (bit_phase == '0)
		&& (shift_count < DATA_BITS);

	// shifts taken in the current window
	always_ff @(posedge clk) begin
		if (clear_all || !data_window) begin
			shift_count <= '0;
		end else if (shift_tick) begin
			shift_count <= shift_count + 1'h1;
		end
	end

	// control register takes data only until the entry is held
	assign control_port.shift_en   = shift_tick && !entry_held;
	assign control_port.serial_bit = rx_sync;
	assign control_port.clear      = clear_in;

	char_shift_register control_reg (
		.clk     (clk),
		.sys_rst (sys_rst),
		.port    (control_port)
	);

	// first digit register opens behind the held entry, shuts on done
	assign digit_port.shift_en = shift_tick && entry_held
		&& !first_digit_done;
	assign digit_port.serial_bit = rx_sync;
	assign digit_port.clear      = clear_in;

	char_shift_register first_digit_register (
		.clk     (clk),
		.sys_rst (sys_rst),
		.port    (digit_port)
	);

	// pattern checks, looked at only once the window has closed
	assign entry_match = (control_port.stages[7:0] == ENTRY_PATTERN);
	assign suffix_match = (digit_port.stages[SUFFIX_FIELD_LO +: 4]
		== DIGIT_SUFFIX);

	// first received bit sits highest, and it is the code's low bit
	assign digit_code = {digit_port.stages[DIGIT_FIELD_LO],
		digit_port.stages[DIGIT_FIELD_LO + 1],
		digit_port.stages[DIGIT_FIELD_LO + 2],
		digit_port.stages[DIGIT_FIELD_LO + 3]};

	// entry latch: any other character leaves it untouched
	always_comb begin
		if (clear_in) begin
			next_entry_held = 1'h0;
		end else begin
			next_entry_held = entry_held
				|| (!data_window && entry_match);
		end
	end

	// digit done: suffix seen after a complete character
	always_comb begin
		if (clear_in) begin
			next_done = 1'h0;
		end else begin
			next_done = first_digit_done || (entry_held
				&& !data_window && suffix_match);
		end
	end

	// selects: silent while shifting, zero only after a real zero
	always_comb begin
		next_select_n = select_of(digit_code);
		if (clear_in || !next_entry_held || next_data_window) begin
			next_select_n = SELECT_NONE;
		end
		if (!next_done) begin
			next_select_n[0] = 1'h1;
		end
	end

	// entry state
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			entry_held <= 1'h0;
		end else begin
			entry_held <= next_entry_held;
		end
	end

	// entry gate hidden while the window is open, so register contents
	// in motion can never look like an entry
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			entry_gate <= 1'h0;
		end else begin
			entry_gate <= next_entry_held && !next_data_window;
		end
	end

	// done latch, held until the clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			first_digit_done <= 1'h0;
		end else begin
			first_digit_done <= next_done;
		end
	end

	// active-low digit selects straight from flops
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			digit_select_n <= SELECT_NONE;
		end else begin
			digit_select_n <= next_select_n;
		end
	end

endmodule

`default_nettype wire

// file: shared/ascii_decoder_pkg.sv
`default_nettype none

package ascii_decoder_pkg;

	// system clock rate and the derived cycles per millisecond
	localparam int CLK_HZ        = 10_000_000;
	localparam int CYCLES_PER_MS = CLK_HZ / 1000;

	// start-detect one-shot, a little longer than one start bit
	localparam int START_MS     = 11;
	localparam int START_CYCLES = START_MS * CYCLES_PER_MS;

	// data window length, covers data bits 1 to 8 only
	localparam int WINDOW_MS     = 70;
	localparam int WINDOW_CYCLES = WINDOW_MS * CYCLES_PER_MS;

	// gated bit clock: repetition rate and high time set independently
	localparam int BIT_CLOCK_HZ      = 122;
	localparam int BIT_PERIOD_CYCLES = CLK_HZ / BIT_CLOCK_HZ;
	localparam int BIT_HIGH_PCT      = 50;
	localparam int BIT_HIGH_CYCLES   = BIT_PERIOD_CYCLES * BIT_HIGH_PCT / 100;

	// counter and register widths
	localparam int COUNT_W   = 20;
	localparam int REG_W     = 10;
	localparam int SECTION_W = 5;
	localparam int DIGITS    = 10;
	localparam int SHIFT_W   = 4;

	// number of data bits shifted per character
	localparam logic [SHIFT_W-1:0] DATA_BITS = 4'h8;

	// entry character as seen on stages 8 down to 1
	localparam logic [7:0] ENTRY_PATTERN = 8'h19;

	// trailing four bits of every digit, stages 4 down to 1
	localparam logic [3:0] DIGIT_SUFFIX = 4'hD;

	// field positions in the stage vector (bit 0 is stage 1)
	localparam int DIGIT_FIELD_LO  = 4;
	localparam int SUFFIX_FIELD_LO = 0;

	// all selects high means nothing selected
	localparam logic [DIGITS-1:0] SELECT_NONE = 10'h3FF;

	// marking level of an idle line
	localparam logic RX_IDLE = 1'h1;

endpackage

`default_nettype wire

// file: shared/shift_port_if.sv
`default_nettype none

// joins the decoder control logic to one character shift register
interface shift_port_if
	import ascii_decoder_pkg::*;
;
	logic             shift_en;
	logic             serial_bit;
	logic             clear;
	logic [REG_W-1:0] stages;

	modport feeder (output shift_en, output serial_bit, output clear,
		input stages);
	modport storage (input shift_en, input serial_bit, input clear,
		output stages);
endinterface

`default_nettype wire

// file: src/char_shift_register.sv
`default_nettype none

// serial-in parallel-out register made of two cascaded sections
module char_shift_register
	import ascii_decoder_pkg::*;
(
	input  wire logic     clk,
	input  wire logic     sys_rst,
	shift_port_if.storage port
);

	logic [SECTION_W-1:0] low_section;
	logic [SECTION_W-1:0] high_section;

	// first section: stage 1 takes the serial bit, the rest move up
	always_ff @(posedge clk) begin
		if (sys_rst || port.clear) begin
			low_section <= '0;
		end else if (port.shift_en) begin
			low_section <= {low_section[SECTION_W-2:0],
				port.serial_bit};
		end
	end

	// second section is fed from the last stage of the first
	always_ff @(posedge clk) begin
		if (sys_rst || port.clear) begin
			high_section <= '0;
		end else if (port.shift_en) begin
			high_section <= {high_section[SECTION_W-2:0],
				low_section[SECTION_W-1]};
		end
	end

	// parallel view, bit 0 is stage 1
	assign port.stages = {high_section, low_section};

endmodule

`default_nettype wire

// file: testbench/decoder_assertions.sv
`default_nettype none

// watches only the decoder top ports
module decoder_checker
	import ascii_decoder_pkg::*;
#(
	parameter int START_LEN  = START_CYCLES,
	parameter int WINDOW_LEN = WINDOW_CYCLES
) (
	input wire logic              clk,
	input wire logic              sys_rst,
	input wire logic              rx_line,
	input wire logic              clear_in,
	input wire logic              start_detect,
	input wire logic              data_window,
	input wire logic              bit_clock,
	input wire logic              entry_gate,
	input wire logic              first_digit_done,
	input wire logic [DIGITS-1:0] digit_select_n
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [COUNT_W-1:0] sd_cnt;
	logic [COUNT_W-1:0] win_cnt;

	// high-time counters; cleared with the design so a clear cut is no error
	always_ff @(posedge clk) begin
		if (sys_rst || clear_in) begin
			sd_cnt  <= '0;
			win_cnt <= '0;
		end else begin
			sd_cnt  <= start_detect ? sd_cnt + 1'b1 : '0;
			win_cnt <= data_window ? win_cnt + 1'b1 : '0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_start_cause: assert property ($rose(start_detect) |->
		!$past(rx_line, 3) && $past(rx_line, 5))
		else $error("start pulse without a line fall");
	a_start_width: assert property ($fell(start_detect) &&
		!$past(clear_in) |-> sd_cnt == START_LEN)
		else $error("start pulse length wrong");
	a_window_cause: assert property ($rose(data_window) |->
		$fell(start_detect))
		else $error("window opened without start pulse end");
	a_window_width: assert property ($fell(data_window) &&
		!$past(clear_in) |-> win_cnt == WINDOW_LEN)
		else $error("window length wrong");
	a_clock_gated: assert property ($rose(data_window) |=>
		bit_clock [*4] ##1 !bit_clock)
		else $error("bit clock pulse wrong");
	a_entry_masked: assert property (data_window |-> !entry_gate)
		else $error("entry gate high in window");
	// after a digit window the gate returns on the very edge the window
	// ends, after the entry window one edge later; both follow a window
	a_entry_rise: assert property ($rose(entry_gate) |->
		$past(data_window, 2) && !data_window)
		else $error("entry gate rose off the window end");
	a_quiet_shift: assert property (data_window |->
		digit_select_n == SELECT_NONE)
		else $error("select active while shifting");
	a_zero_done: assert property (!digit_select_n[0] |->
		first_digit_done)
		else $error("zero select without done");
	a_one_low: assert property (digit_select_n != SELECT_NONE |->
		$onehot(~digit_select_n))
		else $error("more than one select low");
	a_clear_wipes: assert property (clear_in |=> !entry_gate &&
		!first_digit_done && digit_select_n == SELECT_NONE)
		else $error("clear left state behind");
endmodule

bind ascii_digit_selection_decoder decoder_checker #(
	.START_LEN (START_LEN),
	.WINDOW_LEN(WINDOW_LEN)
) chk (.*);

`default_nettype wire

// file: testbench/modem_model.sv
`default_nettype none

// far end: start bit, eight bits first-received first, one stop bit
module modem_model #(
	parameter int CELL = 9
) (
	input  wire logic clk,
	output var  logic rx_line
);
	timeunit 1ns;
	timeprecision 1ns;

	// line idles at mark between characters
	initial rx_line = 1'h1;

	task automatic send_char(input logic [7:0] bits);
		logic [9:0] frame;
		frame = {1'h1, bits, 1'h0};
		for (int i = 0; i < 10 * CELL; i++) begin
			@(posedge clk);
			#1 rx_line <= frame[i / CELL];
		end
	endtask
endmodule

`default_nettype wire

// file: testbench/tb.sv
`default_nettype none

module tb
	import ascii_decoder_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic              clk;
	logic              sys_rst;
	logic              clear_in;
	logic              rx_line;
	logic              start_detect;
	logic              data_window;
	logic              bit_clock;
	logic              entry_gate;
	logic              first_digit_done;
	logic [DIGITS-1:0] digit_select_n;
	int                fails;
	int                total_checks;

	// short counts keep the run brief; the modem cell equals the period
	localparam int T_START  = 11;
	localparam int T_WINDOW = 70;
	localparam int T_PERIOD = 9;
	localparam int T_HIGH   = 4;

	modem_model #(.CELL(T_PERIOD)) modem (.clk(clk), .rx_line(rx_line));

	ascii_digit_selection_decoder #(
		.START_LEN (T_START),
		.WINDOW_LEN(T_WINDOW),
		.BIT_PERIOD(T_PERIOD),
		.BIT_HIGH  (T_HIGH)
	) dut (.clk(clk), .sys_rst(sys_rst), .rx_line(rx_line),
		.clear_in(clear_in), .start_detect(start_detect),
		.data_window(data_window), .bit_clock(bit_clock),
		.entry_gate(entry_gate), .first_digit_done(first_digit_done),
		.digit_select_n(digit_select_n));

	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// bounded wait for the window and start pulse to go quiet
	task automatic settle;
		int n;
		n = 0;
		while ((data_window !== 1'h0 || start_detect !== 1'h0) && n < 300) begin
			@(posedge clk);
			n++;
		end
		if (n == 300) begin
			fails++;
			wrap_up();
		end
		repeat (3) @(posedge clk);
		#2;
	endtask

	task automatic clear_all;
		@(posedge clk);
		#1 clear_in <= 1'h1;
		repeat (3) @(posedge clk);
		#1 clear_in <= 1'h0;
		@(posedge clk);
		#2;
	endtask

	// characters are given first-received bit in bit 0
	initial begin
		logic [9:0] exp;
		sys_rst = 1'h1;
		clear_in = 1'h0;
		fails = 0;
		total_checks = 0;
		repeat (10) @(posedge clk);
		#1 sys_rst <= 1'h0;
		@(posedge clk);
		#2;
		check(digit_select_n, SELECT_NONE);
		modem.send_char(8'hB3);
		settle();
		check({entry_gate, first_digit_done}, 2'h0);
		modem.send_char(8'h99);
		settle();
		check(entry_gate, 1'h0);
		// each four-bit code after an entry character
		for (int d = 0; d < 16; d++) begin
			clear_all();
			check({entry_gate, first_digit_done}, 2'h0);
			modem.send_char(8'h98);
			// one pass sends the digit back to back with the entry
			if (d != 7) begin
				settle();
				check(entry_gate, 1'h1);
			end
			modem.send_char(8'hB0 | 8'(d));
			settle();
			exp = (d < 10) ? ~(10'h1 << d) : SELECT_NONE;
			check({entry_gate, first_digit_done, digit_select_n},
				{2'h3, exp});
			// a later digit must not disturb the frozen register
			if (d == 5) begin
				modem.send_char(8'hB2);
				settle();
				check(digit_select_n, exp);
			end
		end
		wrap_up();
	end
endmodule

`default_nettype wire
